// [fsmr_regs.sv]
// Fault status, supply flags, electrochrome comparators, mask config and serial access
`timescale 1ns/1ps
`default_nettype none
module fsmr_regs
  import fsmr_pkg::*;
#(
  parameter int UC_CYC = UC_FILT_CYC,
  parameter int ECV_CYC = ECV_SETTLE_CYC,
  parameter int RECOV_CYC = OC_RECOV_CYC
) (
  // Core clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Serial link
  input wire logic sclk_i,
  input wire logic csn_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // Analog comparator pins
  input wire logic [NCH-1:0] oc_raw_i,
  input wire logic [NCH-1:0] uc_raw_i,
  input wire logic supply_uv_raw_i,
  input wire logic supply_ov_raw_i,
  input wire logic ecv_below_raw_i,
  input wire logic ecv_above_raw_i,
  // Core-side control and neighbouring status
  input wire logic [NCH-1:0] out_req_i,
  input wire logic ecv_mode_i,
  input wire logic oc_recov_en_i,
  input wire logic manual_restart_i,
  input wire logic temp_warn_i,
  input wire logic output_one_hs_uc_i,
  input wire logic output_one_ls_uc_i,
  input wire logic other_uc_i,
  // Driver enables and global status
  output logic [NCH-1:0] drv_en_o,
  output logic global_err_o,
  output logic openload_o
);

  if (UC_CYC < 1 || ECV_CYC < 1 || RECOV_CYC < 1) begin : g_chk
    $error("fsmr_regs: timing counts must be at least 1");
  end

  // ---------------- Link domain ----------------
  logic lrst_n;
  logic [4:0] bcnt_q;
  logic [FRAME_BITS-2:0] shin_q;
  logic [FRAME_BITS-1:0] fr_q;
  logic ftog_q;
  logic [DATA_W-1:0] shout_q;
  logic [DATA_W-1:0] rd_stat_q;
  logic [DATA_W-1:0] rd_cfg_q;
  logic [DATA_W-1:0] rd_word;
  logic [ADDR_BITS-1:0] rd_addr;

  // Deselect clears the bit counter, so a short frame is simply dropped
  assign lrst_n = rstn_i & ~csn_i;

  always_ff @(posedge sclk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      bcnt_q <= '0;
      shin_q <= '0;
    end else begin
      shin_q <= {shin_q[FRAME_BITS-3:0], sdi_i};
      // Counter parks one past the last bit so extra clocks cannot relatch a frame
      if (bcnt_q <= BCNT_LAST) begin
        bcnt_q <= bcnt_q + 1'b1;
      end
    end
  end

  // Frame word stays put until the next full frame, so the toggle carries it safely
  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fr_q <= '0;
      ftog_q <= 1'b0;
    end else if (bcnt_q == BCNT_LAST && !csn_i) begin
      fr_q <= {shin_q, sdi_i};
      ftog_q <= ~ftog_q;
    end
  end

  // Read snapshots are frozen in the core domain while the link is selected
  assign rd_addr = shin_q[ADDR_BITS-1:0];
  always_comb begin
    rd_word = '0;
    if (rd_addr == FAULT_STATUS_TWO_ADDR) begin
      rd_word = rd_stat_q;
    end else if (rd_addr == FAULT_MASK_CONFIG_ADDR) begin
      rd_word = rd_cfg_q;
    end
  end

  always_ff @(negedge sclk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      shout_q <= '0;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else begin
      sdo_oe_o <= 1'b1;
      if (bcnt_q == BCNT_DATA) begin
        sdo_o <= rd_word[DATA_W-1];
        shout_q <= {rd_word[DATA_W-2:0], 1'b0};
      end else begin
        sdo_o <= shout_q[DATA_W-1];
        shout_q <= {shout_q[DATA_W-2:0], 1'b0};
      end
    end
  end

  // ---------------- Core domain ----------------
  logic [NCH-1:0] oc_s;
  logic [NCH-1:0] uc_s;
  logic uv_s;
  logic ov_s;
  logic ecv_below_s;
  logic ecv_above_s;
  logic csn_s;
  logic ftog_s;
  logic ftog_d_q;

  fsmr_sync #(.W(2 * NCH + 4)) u_pin_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i({oc_raw_i, uc_raw_i, supply_uv_raw_i, supply_ov_raw_i, ecv_below_raw_i,
          ecv_above_raw_i}),
    .q_o({oc_s, uc_s, uv_s, ov_s, ecv_below_s, ecv_above_s})
  );

  logic ftog_i_w;
  assign ftog_i_w = ftog_q;

  fsmr_sync #(.W(2)) u_link_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i({csn_i, ftog_i_w}),
    .q_o({csn_s, ftog_s})
  );

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ftog_d_q <= 1'b0;
    end else begin
      ftog_d_q <= ftog_s;
    end
  end

  logic frame_evt;
  logic cfg_wr;
  logic st_wr;
  logic [DATA_W-1:0] fr_data;
  assign frame_evt = ftog_s ^ ftog_d_q;
  assign fr_data = fr_q[DATA_W-1:0];
  assign cfg_wr = frame_evt && fr_q[WR_BIT] &&
                  fr_q[ADDR_LSB +: ADDR_BITS] == FAULT_MASK_CONFIG_ADDR;
  assign st_wr = frame_evt && fr_q[WR_BIT] &&
                 fr_q[ADDR_LSB +: ADDR_BITS] == FAULT_STATUS_TWO_ADDR;

  // Reserved bits are held at zero whatever is written
  logic [DATA_W-1:0] cfg_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_q <= CFG_RST;
    end else if (cfg_wr) begin
      cfg_q <= fr_data & CFG_WMASK;
    end
  end

  // Per-channel flags; a set in the clear cycle wins
  logic [NCH-1:0] oc_q;
  logic [NCH-1:0] uc_q;
  logic [NCH-1:0] ocoff_q;
  logic [NCH-1:0] uc_lvl;
  logic [NCH-1:0] uc_hit;
  logic [NCH-1:0] rec_lvl;
  logic [NCH-1:0] rec_hit;
  logic sup_off_q;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign uc_lvl[i] = uc_s[i] & drv_en_o[i];
    assign rec_lvl[i] = ocoff_q[i] & oc_recov_en_i & ~oc_s[i];

    fsmr_hold #(.N(UC_CYC)) u_uc_hold (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .lvl_i(uc_lvl[i]),
      .hit_o(uc_hit[i])
    );

    fsmr_hold #(.N(RECOV_CYC)) u_rec_hold (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .lvl_i(rec_lvl[i]),
      .hit_o(rec_hit[i])
    );

    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        oc_q[i] <= 1'b0;
      end else begin
        oc_q[i] <= oc_s[i] | (oc_q[i] & ~(st_wr & fr_data[oc_pos(i)]));
      end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        uc_q[i] <= 1'b0;
      end else begin
        uc_q[i] <= uc_hit[i] | (uc_q[i] & ~(st_wr & fr_data[uc_pos(i)]));
      end
    end

    // Trip holds the driver off until timed recovery or a cleared flag
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        ocoff_q[i] <= 1'b0;
      end else if (oc_s[i]) begin
        ocoff_q[i] <= 1'b1;
      end else if (oc_recov_en_i && rec_hit[i]) begin
        ocoff_q[i] <= 1'b0;
      end else if (!oc_recov_en_i && !oc_q[i]) begin
        ocoff_q[i] <= 1'b0;
      end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        drv_en_o[i] <= 1'b0;
      end else begin
        drv_en_o[i] <= out_req_i[i] & ~oc_s[i] & ~ocoff_q[i] & ~uv_s & ~ov_s &
                       ~sup_off_q;
      end
    end
  end

  // Supply flags and output shutdown
  logic uv_q;
  logic ov_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      uv_q <= 1'b0;
      ov_q <= 1'b0;
    end else begin
      uv_q <= uv_s | (uv_q & ~(st_wr & fr_data[ST_SUPPLY_UV]));
      ov_q <= ov_s | (ov_q & ~(st_wr & fr_data[ST_SUPPLY_OV]));
    end
  end

  // Manual restart waits for software to clear both supply flags
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sup_off_q <= 1'b0;
    end else if (uv_s || ov_s) begin
      sup_off_q <= 1'b1;
    end else if (!manual_restart_i || (!uv_q && !ov_q)) begin
      sup_off_q <= 1'b0;
    end
  end

  // Electrochrome comparator bits follow the inputs after a settle time
  logic [1:0] ecv_q;
  logic [1:0] ecv_cmp;
  logic [1:0] ecv_hit;
  assign ecv_cmp = {ecv_below_s, ecv_above_s};

  for (genvar j = 0; j < 2; j++) begin : g_ecv
    fsmr_hold #(.N(ECV_CYC)) u_ecv_hold (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .lvl_i(ecv_mode_i && (ecv_cmp[j] != ecv_q[j])),
      .hit_o(ecv_hit[j])
    );

    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        ecv_q[j] <= 1'b0;
      end else if (!ecv_mode_i) begin
        ecv_q[j] <= 1'b0;
      end else if (ecv_hit[j]) begin
        ecv_q[j] <= ecv_cmp[j];
      end
    end
  end

  // Status word and global flags
  logic [DATA_W-1:0] stat_w;
  logic ol_w;
  logic err_w;
  always_comb begin
    stat_w = '0;
    for (int k = 0; k < NCH; k++) begin
      stat_w[oc_pos(k)] = oc_q[k];
      stat_w[uc_pos(k)] = uc_q[k];
    end
    stat_w[ST_SUPPLY_UV] = uv_q;
    stat_w[ST_SUPPLY_OV] = ov_q;
    stat_w[ST_ECV_LOW] = ecv_q[1];
    stat_w[ST_ECV_HIGH] = ecv_q[0];
  end

  assign ol_w = (|uc_q) | other_uc_i |
                (output_one_hs_uc_i & ~cfg_q[CFG_M_HS1_UC]) |
                (output_one_ls_uc_i & ~cfg_q[CFG_M_LS1_UC]);
  // Comparator bits are left out of the error sum on purpose
  assign err_w = (|oc_q) | uv_q | ov_q |
                 (temp_warn_i & ~cfg_q[CFG_M_TEMP]) |
                 (ol_w & ~cfg_q[CFG_M_OPENLOAD]);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      global_err_o <= 1'b0;
      openload_o <= 1'b0;
    end else begin
      global_err_o <= err_w;
      openload_o <= ol_w;
    end
  end

  // Snapshots only move while deselected so the link sees stable words
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_stat_q <= '0;
      rd_cfg_q <= CFG_RST;
    end else if (csn_s) begin
      rd_stat_q <= stat_w;
      rd_cfg_q <= cfg_q;
    end
  end

  // ---------------- Checks ----------------
  int unsigned uc_run_q;
  int unsigned ecv_age_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      uc_run_q <= 0;
      ecv_age_q <= 0;
    end else begin
      uc_run_q <= uc_lvl[0] ? uc_run_q + 1 : 0;
      ecv_age_q <= (ecv_q[0] != ecv_cmp[0] && ecv_hit[0]) ? 0 : ecv_age_q + 1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_oc_drv_off: assert property (oc_s[0] |=> !drv_en_o[0] && oc_q[0])
    else $error("over-current did not flag and disable the driver");
  a_oc_manual_hold: assert property (
    ocoff_q[0] && !oc_recov_en_i |=> !drv_en_o[0])
    else $error("driver restarted before over-current flag cleared");
  a_oc_auto_back: assert property (
    rec_hit[0] && oc_recov_en_i && !oc_s[0] |=> !ocoff_q[0])
    else $error("recovery delay expired but driver stayed off");
  a_uc_filter_time: assert property (
    $rose(uc_q[0]) |-> $past(uc_run_q) >= UC_CYC)
    else $error("under-current flag set before filter time");
  a_supply_shutdown: assert property (
    uv_s || ov_s |=> drv_en_o == '0 && (uv_q || ov_q))
    else $error("supply fault did not flag and disable outputs");
  a_manual_restart: assert property (
    sup_off_q && manual_restart_i && (uv_q || ov_q) |=> sup_off_q)
    else $error("outputs restarted despite manual restart");
  a_ecv_spacing: assert property (
    ecv_mode_i && $past(ecv_mode_i) && $changed(ecv_q[0]) |-> $past(ecv_age_q) >= ECV_CYC)
    else $error("electrochrome bit changed too soon");
  a_temp_masked: assert property (
    cfg_q[CFG_M_TEMP] && !(|oc_q) && !uv_q && !ov_q &&
    !(ol_w && !cfg_q[CFG_M_OPENLOAD]) |=> !global_err_o)
    else $error("masked temperature warning reached global error");
  a_err_from_oc: assert property ((|oc_q) |=> global_err_o)
    else $error("over-current flag missing from global error");
  a_hs1_masked: assert property (
    cfg_q[CFG_M_HS1_UC] && !(|uc_q) && !other_uc_i && !output_one_ls_uc_i |=> !openload_o)
    else $error("masked output one highside under-current reached openload");

endmodule : fsmr_regs
`default_nettype wire

// [fsmr_pkg.sv]
// Constants, field positions and decode helpers for the fault status and mask block
package fsmr_pkg;

  // Clock and timing
  localparam int CLK_MHZ = 250;
  localparam int UC_FILT_MS = 1;
  localparam int UC_FILT_CYC = UC_FILT_MS * 1000 * CLK_MHZ;
  localparam int ECV_SETTLE_US = 32;
  localparam int ECV_SETTLE_CYC = ECV_SETTLE_US * CLK_MHZ;
  localparam int OC_RECOV_US = 100;
  localparam int OC_RECOV_CYC = OC_RECOV_US * CLK_MHZ;

  // Channels: five highside outputs plus the electrochrome drive
  localparam int NCH = 6;

  // Serial frame: write flag, 7-bit address, 16-bit data, MSB first
  localparam int DATA_W = 16;
  localparam int ADDR_BITS = 7;
  localparam int CMD_BITS = 8;
  localparam int FRAME_BITS = 24;
  localparam int WR_BIT = 23;
  localparam int ADDR_LSB = 16;
  localparam logic [4:0] BCNT_LAST = 5'h17;
  localparam logic [4:0] BCNT_DATA = 5'h08;

  // Register addresses
  localparam logic [ADDR_BITS-1:0] FAULT_STATUS_TWO_ADDR = 7'h02;
  localparam logic [ADDR_BITS-1:0] FAULT_MASK_CONFIG_ADDR = 7'h3F;

  // Status field positions
  localparam int ST_SUPPLY_UV = 3;
  localparam int ST_SUPPLY_OV = 2;
  localparam int ST_ECV_LOW = 1;
  localparam int ST_ECV_HIGH = 0;

  // Config field positions, writable bits and reset value
  localparam int CFG_M_HS1_UC = 5;
  localparam int CFG_M_LS1_UC = 4;
  localparam int CFG_M_TEMP = 3;
  localparam int CFG_M_OPENLOAD = 1;
  localparam logic [DATA_W-1:0] CFG_WMASK = 16'h003A;
  localparam logic [DATA_W-1:0] CFG_RST = 16'h0000;

  function automatic int oc_pos(input int ch);
    return 15 - 2 * ch;
  endfunction : oc_pos

  function automatic int uc_pos(input int ch);
    return 14 - 2 * ch;
  endfunction : uc_pos

endpackage : fsmr_pkg

// [fsmr_sync.sv]
// Two-flop synchroniser for levels entering the core clock domain
`timescale 1ns/1ps
`default_nettype none
module fsmr_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  if (W < 1) begin : g_chk
    $error("fsmr_sync: W must be at least 1");
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule : fsmr_sync
`default_nettype wire

// [fsmr_hold.sv]
// Persistence filter: hit goes high once the level has held for N cycles
`timescale 1ns/1ps
`default_nettype none
module fsmr_hold #(
  parameter int N = 4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic lvl_i,
  output logic hit_o
);
  localparam int W = $clog2(N + 1);
  localparam logic [W-1:0] LAST = W'(N - 1);
  logic [W-1:0] cnt_q;

  if (N < 1) begin : g_chk
    $error("fsmr_hold: N must be at least 1");
  end

  // Counter saturates so a long level keeps hit asserted
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
    end else if (!lvl_i) begin
      cnt_q <= '0;
    end else if (cnt_q != LAST) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hit_o <= 1'b0;
    end else begin
      hit_o <= lvl_i && (cnt_q == LAST);
    end
  end
endmodule : fsmr_hold
`default_nettype wire

// [fsmr_spi_master.sv]
// Serial link master model driving 24-bit frames on its own 6 ns clock
`timescale 1ns/1ps
`default_nettype none
module fsmr_spi_master
  import fsmr_pkg::*;
(
  // Link pins
  output logic sclk_o,
  output logic csn_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  initial begin
    sclk_o = 1'b0;
    csn_o = 1'b1;
    sdi_o = 1'b0;
  end

  // Clock stands still between frames; data line then shows the inverse of its last bit
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [15:0] wdat,
      output logic [15:0] rdat);
    logic [23:0] frm;
    if (wr && addr == FAULT_MASK_CONFIG_ADDR) wdat = wdat & CFG_WMASK;
    frm = {wr, addr, wdat};
    rdat = 16'h0000;
    csn_o = 1'b0;
    #21;
    for (int i = 23; i >= 0; i--) begin
      sdi_o = frm[i];
      #3;
      // A released data line must not pass for a valid bit
      if (i < 16) rdat[i] = sdo_oe_i ? sdo_i : 1'bx;
      sclk_o = 1'b1;
      #3;
      sclk_o = 1'b0;
    end
    #3;
    csn_o = 1'b1;
    sdi_o = ~sdi_o;
    #60;
  endtask : xfer
endmodule : fsmr_spi_master
`default_nettype wire

// [test_fault_status_and_mask_regs.sv]
// Self-checking bench for the fault status and mask register block
`timescale 1ns/1ps
`default_nettype none
module test_fault_status_and_mask_regs;
  import fsmr_pkg::*;
  localparam int UC_P = 20;
  localparam int ECV_P = 10;
  localparam int REC_P = 15;
  localparam logic [6:0] ST = FAULT_STATUS_TWO_ADDR;
  localparam logic [6:0] CF = FAULT_MASK_CONFIG_ADDR;
  logic clk_i, rstn_i, sclk, csn, sdi, sdo, sdo_oe;
  logic [NCH-1:0] oc_raw, uc_raw, out_req, drv_en;
  logic uv, ov, ecv_lo, ecv_hi, ecv_mode, recov, manual, temp, hs1, ls1, other_uc;
  logic global_err, openload;
  logic [15:0] rd;
  int mismatches, samples_checked, cycles;

  fsmr_regs #(.UC_CYC(UC_P), .ECV_CYC(ECV_P), .RECOV_CYC(REC_P)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .csn_i(csn), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .oc_raw_i(oc_raw), .uc_raw_i(uc_raw),
    .supply_uv_raw_i(uv), .supply_ov_raw_i(ov), .ecv_below_raw_i(ecv_lo),
    .ecv_above_raw_i(ecv_hi), .out_req_i(out_req), .ecv_mode_i(ecv_mode),
    .oc_recov_en_i(recov), .manual_restart_i(manual), .temp_warn_i(temp),
    .output_one_hs_uc_i(hs1), .output_one_ls_uc_i(ls1), .other_uc_i(other_uc),
    .drv_en_o(drv_en), .global_err_o(global_err), .openload_o(openload));

  fsmr_spi_master u_mst (.sclk_o(sclk), .csn_o(csn), .sdi_o(sdi), .sdo_i(sdo),
    .sdo_oe_i(sdo_oe));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  task automatic rdreg(input logic [6:0] a, output logic [15:0] d);
    u_mst.xfer(1'b0, a, 16'h0000, d);
    @(negedge clk_i);
  endtask : rdreg

  task automatic wrreg(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] dummy;
    u_mst.xfer(1'b1, a, d, dummy);
    @(negedge clk_i);
  endtask : wrreg

  task automatic t_regs;
    rdreg(CF, rd);
    chk("cfg reset", 16'h0000, rd);
    rdreg(ST, rd);
    chk("status reset", 16'h0000, rd);
    rdreg(7'h11, rd);
    chk("unmapped read", 16'h0000, rd);
    wrreg(CF, 16'h003A);
    wrreg(7'h11, 16'h0000);
    rdreg(CF, rd);
    chk("cfg readback", 16'h003A, rd);
    wrreg(CF, 16'h0000);
    $display("t_regs done");
  endtask : t_regs

  // Every channel, the electrochrome drive included, trips and waits for a clear
  task automatic t_oc;
    logic [15:0] bitv;
    for (int i = 0; i < NCH; i++) begin
      bitv = 16'h8000 >> (2 * i);
      oc_raw[i] = 1'b1;
      cyc(5);
      chk("drv off", 16'(6'h3F & ~(6'h01 << i)), 16'(drv_en));
      chk("gerr oc", 16'h0001, 16'(global_err));
      oc_raw[i] = 1'b0;
      cyc(30);
      chk("no restart", 16'(6'h3F & ~(6'h01 << i)), 16'(drv_en));
      rdreg(ST, rd);
      chk("oc flag", bitv, rd);
      wrreg(ST, bitv);
      chk("restart", 16'h003F, 16'(drv_en));
      chk("gerr clr", 16'h0000, 16'(global_err));
    end
    $display("t_oc done");
  endtask : t_oc

  task automatic t_recov;
    recov = 1'b1;
    oc_raw[0] = 1'b1;
    cyc(4);
    chk("trip", 16'h003E, 16'(drv_en));
    oc_raw[0] = 1'b0;
    cyc(8);
    chk("still off", 16'h003E, 16'(drv_en));
    cyc(15);
    chk("auto on", 16'h003F, 16'(drv_en));
    rdreg(ST, rd);
    chk("flag kept", 16'h8000, rd);
    wrreg(ST, 16'h8000);
    recov = 1'b0;
    $display("t_recov done");
  endtask : t_recov

  // Channel 3 is low too, but with its driver off it must never flag
  // Channel 0 flags; the requested outputs stay on throughout, as an under-current flag does not switch a driver off
  task automatic t_uc;
    out_req = 6'h37;
    uc_raw = 6'h09;
    cyc(10);
    chk("uc early", 16'h0000, 16'(openload));
    cyc(UC_P);
    chk("uc set", 16'h0001, 16'(openload));
    chk("gerr uc", 16'h0001, 16'(global_err));
    wrreg(CF, 16'h0002);
    chk("gerr masked", 16'h0000, 16'(global_err));
    chk("ol kept", 16'h0001, 16'(openload));
    rdreg(ST, rd);
    chk("uc flag", 16'h4000, rd);
    uc_raw = 6'h00;
    out_req = 6'h3F;
    wrreg(ST, 16'h4000);
    wrreg(CF, 16'h0000);
    chk("ol clr", 16'h0000, 16'(openload));
    $display("t_uc done");
  endtask : t_uc

  task automatic t_supply;
    for (int k = 0; k < 2; k++) begin
      manual = k[0];
      {uv, ov} = k ? 2'b01 : 2'b10;
      cyc(5);
      chk("supply off", 16'h0000, 16'(drv_en));
      {uv, ov} = 2'b00;
      cyc(6);
      chk("supply back", k ? 16'h0000 : 16'h003F, 16'(drv_en));
      rdreg(ST, rd);
      chk("supply flag", k ? 16'h0004 : 16'h0008, rd);
      wrreg(ST, rd);
      chk("after clear", 16'h003F, 16'(drv_en));
    end
    manual = 1'b0;
    $display("t_supply done");
  endtask : t_supply

  task automatic t_mask;
    logic [15:0] mk [4] = '{16'h0020, 16'h0010, 16'h0008, 16'h0002};
    // A temperature warning alone never raises openload
    logic [3:0] ol_exp = 4'b1101;
    for (int k = 0; k < 4; k++) begin
      {hs1, ls1, temp, other_uc} = 4'b1000 >> k;
      cyc(4);
      chk("ol open", 16'(ol_exp[3-k]), 16'(openload));
      chk("gerr open", 16'h0001, 16'(global_err));
      wrreg(CF, mk[k]);
      chk("ol mask", 16'(k == 3), 16'(openload));
      chk("gerr mask", 16'h0000, 16'(global_err));
      {hs1, ls1, temp, other_uc} = 4'b0000;
      wrreg(CF, 16'h0000);
    end
    $display("t_mask done");
  endtask : t_mask

  task automatic t_ecv;
    ecv_mode = 1'b1;
    ecv_lo = 1'b1;
    rdreg(ST, rd);
    chk("ecv early", 16'h0000, rd);
    cyc(20);
    rdreg(ST, rd);
    chk("ecv below", 16'h0002, rd);
    chk("ecv no gerr", 16'h0000, 16'(global_err));
    {ecv_lo, ecv_hi} = 2'b01;
    cyc(20);
    rdreg(ST, rd);
    chk("ecv above", 16'h0001, rd);
    ecv_mode = 1'b0;
    cyc(4);
    rdreg(ST, rd);
    chk("ecv off", 16'h0000, rd);
    ecv_hi = 1'b0;
    $display("t_ecv done");
  endtask : t_ecv

  initial begin
    rstn_i = 1'b0;
    {oc_raw, uc_raw, out_req} = '0;
    {uv, ov, ecv_lo, ecv_hi, ecv_mode, recov, manual} = '0;
    {temp, hs1, ls1, other_uc} = '0;
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (20) @(negedge clk_i);
    rstn_i = 1'b1;
    cyc(4);
    chk("drv reset", 16'h0000, 16'(drv_en));
    t_regs();
    out_req = 6'h3F;
    cyc(4);
    t_oc();
    t_recov();
    t_uc();
    t_supply();
    t_mask();
    t_ecv();
    summarize();
  end
endmodule : test_fault_status_and_mask_regs
`default_nettype wire
